// file: logic/epd_top.sv
`timescale 1ns/10ps
module epd_top
   import epd_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic reference_edge_input,
   input  wire logic feedback_edge_input,
   input  wire logic oscillator_disable,
   output logic      pfd_tristate_output,
   output logic      pfd_tristate_output_oe_n,
   output logic      pfd_pull_up,
   output logic      pfd_pull_down,
   output logic      rs_detector_output,
   output logic      lock_pulse_output,
   output logic      oscillator_enable,
   output logic      follower_enable
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= RST_SYNC;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ---------------------------------------------------------------
   // Input edges
   // ---------------------------------------------------------------
   logic ref_rise;
   logic fb_rise;

   epd_edge u_ref_edge (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .level_in (reference_edge_input),
      .rise     (ref_rise)
   );

   epd_edge u_fb_edge (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .level_in (feedback_edge_input),
      .rise     (fb_rise)
   );

   // ---------------------------------------------------------------
   // Phase-frequency detector
   // ---------------------------------------------------------------
   logic up_q;
   logic dn_q;
   logic up_d;
   logic dn_d;

   always_comb begin
      up_d = up_q | ref_rise;
      dn_d = dn_q | fb_rise;
      if (up_d && dn_d) begin
         up_d = 1'b0;
         dn_d = 1'b0;
      end
   end

   // Two D flops with common clear gating
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         up_q <= RST_FLOP;
         dn_q <= RST_FLOP;
      end else begin
         up_q <= up_d;
         dn_q <= dn_d;
      end
   end

   epd_pfd_state_t pfd_state;
   always_comb begin
      unique case ({up_q, dn_q})
         2'b10:   pfd_state = EPD_UP;
         2'b01:   pfd_state = EPD_DOWN;
         default: pfd_state = EPD_IDLE;
      endcase
   end

   // Idle when neither flop holds a pending edge
   function automatic logic pfd_idle(input logic up, input logic dn);
      pfd_idle = ~(up | dn);
   endfunction

   // Three-state stage, drivers off when idle
   assign pfd_pull_up              = (pfd_state == EPD_UP);
   assign pfd_pull_down            = (pfd_state == EPD_DOWN);
   assign pfd_tristate_output      = up_q;
   assign pfd_tristate_output_oe_n = pfd_idle(up_q, dn_q);
   assign lock_pulse_output        = pfd_idle(up_q, dn_q);

   // ---------------------------------------------------------------
   // Set-reset detector
   // ---------------------------------------------------------------
   logic rs_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rs_q <= RST_FLOP;
      end else if (fb_rise && !ref_rise) begin
         rs_q <= 1'b1;
      end else if (ref_rise && !fb_rise) begin
         rs_q <= 1'b0;
      end else if (ref_rise && fb_rise) begin
         rs_q <= ~rs_q;
      end
   end
   assign rs_detector_output = rs_q;

   // ---------------------------------------------------------------
   // Oscillator section control
   // ---------------------------------------------------------------
   logic osc_en_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_en_q <= RST_FLOP;
      end else begin
         osc_en_q <= ~oscillator_disable;
      end
   end
   assign oscillator_enable = osc_en_q;
   assign follower_enable   = osc_en_q;

   // ---------------------------------------------------------------
   // Detector sequences
   // ---------------------------------------------------------------
   sequence s_ref_only;
      ref_rise && !fb_rise && !dn_q;
   endsequence

   sequence s_fb_only;
      fb_rise && !ref_rise && !up_q;
   endsequence

   sequence s_ref_only_off;
      ref_rise && !fb_rise && !dn_q && oscillator_disable;
   endsequence

   sequence s_lead_two;
      s_ref_only ##1 !fb_rise;
   endsequence

   sequence s_lag_two;
      s_fb_only ##1 !ref_rise;
   endsequence

   sequence s_lead_pulse;
      s_ref_only ##1 fb_rise;
   endsequence

   sequence s_lag_pulse;
      s_fb_only ##1 ref_rise;
   endsequence

   // ---------------------------------------------------------------
   // Phase-frequency detector checks
   // ---------------------------------------------------------------
   a_up_on_ref: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_ref_only |=> pfd_pull_up && !pfd_pull_down)
      else $error("Reference edge did not enable pull-up");

   a_dn_on_fb: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_fb_only |=> pfd_pull_down && !pfd_pull_up)
      else $error("Feedback edge did not enable pull-down");

   a_up_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      up_q && !fb_rise |=> up_q)
      else $error("Pull-up ended without feedback edge");

   a_dn_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dn_q && !ref_rise |=> dn_q)
      else $error("Pull-down ended without reference edge");

   a_clear_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
      up_q && fb_rise |=> !up_q && !dn_q)
      else $error("Flops not cleared together");

   a_never_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(pfd_pull_up && pfd_pull_down))
      else $error("Both drivers enabled");

   a_hiz_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pfd_tristate_output_oe_n == (!pfd_pull_up && !pfd_pull_down))
      else $error("Output enable disagrees with drivers");

   a_lock_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      lock_pulse_output == (pfd_state == EPD_IDLE))
      else $error("Lock pulse wrong");

   a_ref_absorb: assert property (@(posedge clk_sys) disable iff (!rst_n)
      up_q && ref_rise && !fb_rise |=> up_q && !dn_q)
      else $error("Extra reference edge disturbed the pull-up");

   a_fb_absorb: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dn_q && fb_rise && !ref_rise |=> dn_q && !up_q)
      else $error("Extra feedback edge disturbed the pull-down");

   a_up_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(up_q) |-> $past(ref_rise))
      else $error("Up count without a reference edge");

   a_dn_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(dn_q) |-> $past(fb_rise))
      else $error("Down count without a feedback edge");

   a_both_cancel: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ref_rise && fb_rise |=> !up_q && !dn_q)
      else $error("Simultaneous edges did not cancel");

   a_dn_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      dn_q && ref_rise |=> !up_q && !dn_q)
      else $error("Pull-down not cleared by reference edge");

   a_lead_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_lead_pulse |=> !pfd_pull_up && !pfd_pull_down && lock_pulse_output)
      else $error("Lead pulse did not end at feedback edge");

   a_lag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_lag_pulse |=> !pfd_pull_up && !pfd_pull_down && lock_pulse_output)
      else $error("Lag pulse did not end at reference edge");

   a_lead_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_lead_two |=> pfd_pull_up)
      else $error("Lead pulse shorter than phase lead");

   a_lag_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_lag_two |=> pfd_pull_down)
      else $error("Lag pulse shorter than phase lag");

   a_idle_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !up_q && !dn_q && !ref_rise && !fb_rise |=> !up_q && !dn_q)
      else $error("Detector left idle without an edge");

   a_lock_drivers: assert property (@(posedge clk_sys) disable iff (!rst_n)
      lock_pulse_output == !(pfd_pull_up || pfd_pull_down))
      else $error("Lock pulse disagrees with drivers");

   a_drive_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !pfd_tristate_output_oe_n |-> pfd_tristate_output == pfd_pull_up)
      else $error("Driven level disagrees with pull-up");

   a_up_out_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pfd_pull_up |-> pfd_tristate_output && !pfd_tristate_output_oe_n)
      else $error("Pull-up without high drive");

   a_dn_out_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pfd_pull_down |-> !pfd_tristate_output && !pfd_tristate_output_oe_n)
      else $error("Pull-down without low drive");

   a_low_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pfd_pull_down && !ref_rise |=> pfd_pull_down)
      else $error("Pull-down released without reference edge");

   a_disable_pfd: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_ref_only_off |=> pfd_pull_up)
      else $error("Detector affected by oscillator disable");

   // ---------------------------------------------------------------
   // Set-reset detector checks
   // ---------------------------------------------------------------
   a_rs_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      fb_rise && !ref_rise |=> rs_detector_output)
      else $error("Set-reset detector not set by feedback");

   a_rs_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ref_rise && !fb_rise |=> !rs_detector_output)
      else $error("Set-reset detector not cleared by reference");

   a_rs_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ref_rise && fb_rise |=> rs_detector_output != $past(rs_detector_output))
      else $error("Set-reset detector did not toggle on both edges");

   a_rs_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !ref_rise && !fb_rise |=> $stable(rs_detector_output))
      else $error("Set-reset detector moved without an edge");

   a_rs_rise_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rs_detector_output) |-> $past(fb_rise))
      else $error("Set-reset detector rose without feedback edge");

   a_rs_fall_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(rs_detector_output) |-> $past(ref_rise))
      else $error("Set-reset detector fell without reference edge");

   a_rs_high_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rs_detector_output && !ref_rise |=> rs_detector_output)
      else $error("Set-reset output dropped without reference edge");

   // ---------------------------------------------------------------
   // Oscillator section checks
   // ---------------------------------------------------------------
   a_osc_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      oscillator_disable |=> !oscillator_enable && !follower_enable)
      else $error("Oscillator running while disabled");

   a_osc_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !oscillator_disable |=> oscillator_enable && follower_enable)
      else $error("Oscillator stopped while enabled");

   a_osc_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(oscillator_enable) |-> !$past(oscillator_disable))
      else $error("Oscillator started while disabled");
endmodule

// file: logic/epd_pkg.sv
package epd_pkg;
   // ---------------------------------------------------------------
   // ---------------------------------------------------------------
   localparam logic       RST_FLOP = 1'b0;
   localparam logic [1:0] RST_SYNC = 2'b00;

   typedef enum logic [2:0] {
      EPD_IDLE = 3'b001,
      EPD_UP   = 3'b010,
      EPD_DOWN = 3'b100
   } epd_pfd_state_t;
endpackage

// file: logic/epd_edge.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Rising edge detector
// ---------------------------------------------------------------
module epd_edge
   import epd_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic level_in,
   output logic      rise
);
   logic prev_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= RST_FLOP;
      end else begin
         prev_q <= level_in;
      end
   end

   assign rise = level_in & ~prev_q;

   a_rise_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rise && $past(rst_n) |-> (level_in && !$past(level_in)))
      else $error("Edge detector fired without a rising transition");
endmodule

// file: tb/epd_src_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Reference and feedback edge source
// ----------------------------------------
module epd_src_model (
   input  wire logic       clk_sys,
   input  wire logic       load,
   input  wire logic       run_ref,
   input  wire logic       run_fb,
   input  wire logic [7:0] ref_per,
   input  wire logic [7:0] fb_per,
   input  wire logic [7:0] fb_start,
   input  wire logic [7:0] duty,
   output logic            ref_out,
   output logic            fb_out
);
   logic [7:0] rc_q;
   logic [7:0] fc_q;
   always_ff @(posedge clk_sys) begin
      rc_q <= (load || rc_q >= ref_per - 8'h01) ? 8'h00 : rc_q + 8'h01;
      fc_q <= load ? fb_start : (fc_q >= fb_per - 8'h01) ? 8'h00 : fc_q + 8'h01;
   end
   // Held low while stopped, so no stray edges
   assign ref_out = run_ref && !load && (rc_q < duty);
   assign fb_out  = run_fb && !load && (fc_q < duty);
endmodule

// file: tb/tb_epd_top.sv
`timescale 1ns/10ps
module tb_epd_top
   import epd_pkg::*;
;
   logic           clk_sys, resetn, ref_in, fb_in, osc_dis, load, run_ref, run_fb;
   logic [7:0]     ref_per, fb_per, fb_start, duty;
   logic           pt_o, pt_oe_n, p_up, p_dn, rs_o, lock_o, osc_en, fol_en;
   logic           rp, fp, r, f, m_rs, m_osc, armed;
   epd_pfd_state_t m_st;
   integer         n_errors, cmp_count, up_n, dn_n, seed, i;
   epd_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .reference_edge_input(ref_in),
      .feedback_edge_input(fb_in), .oscillator_disable(osc_dis), .pfd_tristate_output(pt_o),
      .pfd_tristate_output_oe_n(pt_oe_n), .pfd_pull_up(p_up), .pfd_pull_down(p_dn),
      .rs_detector_output(rs_o), .lock_pulse_output(lock_o), .oscillator_enable(osc_en),
      .follower_enable(fol_en));
   epd_src_model u_src (.clk_sys(clk_sys), .load(load), .run_ref(run_ref), .run_fb(run_fb),
      .ref_per(ref_per), .fb_per(fb_per), .fb_start(fb_start), .duty(duty),
      .ref_out(ref_in), .fb_out(fb_in));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Expected behaviour
   // ----------------------------------------
   always @(posedge clk_sys) begin
      r = ref_in & ~rp;
      f = fb_in & ~fp;
      rp = ref_in;
      fp = fb_in;
      m_osc = ~osc_dis;
      if (!resetn) begin
         m_st = EPD_IDLE;
         m_rs = 1'b0;
      end else begin
         if (r & ~f) m_st = (m_st == EPD_DOWN) ? EPD_IDLE : EPD_UP;
         if (f & ~r) m_st = (m_st == EPD_UP) ? EPD_IDLE : EPD_DOWN;
         if (r & f) m_st = EPD_IDLE;
         m_rs = (r & f) ? ~m_rs : f ? 1'b1 : r ? 1'b0 : m_rs;
      end
   end
   task automatic chk(input logic got, input logic exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(negedge clk_sys) if (armed) begin
      chk(p_up, m_st == EPD_UP);
      chk(p_dn, m_st == EPD_DOWN);
      chk(pt_oe_n, m_st == EPD_IDLE);
      chk(lock_o, m_st == EPD_IDLE);
      chk(rs_o, m_rs);
      chk(osc_en, m_osc);
      chk(fol_en, m_osc);
      if (!pt_oe_n) chk(pt_o, m_st == EPD_UP);
      up_n = up_n + (m_st == EPD_UP);
      dn_n = dn_n + (m_st == EPD_DOWN);
   end
   task automatic run_case(input logic [7:0] rpr, fpr, st, dt, input logic rr,
                           input logic [1:0] ex);
      @(posedge clk_sys);
      {ref_per, fb_per, fb_start, duty, run_ref, run_fb, load} <= {rpr, fpr, st, dt, rr, 2'b11};
      @(posedge clk_sys);
      load <= 1'b0;
      repeat (60) @(posedge clk_sys);
      up_n = 0;
      dn_n = 0;
      repeat (200) begin
         @(posedge clk_sys);
         osc_dis <= ($random(seed) & 7) == 0;
      end
      if (ex == 2'd0) chk(up_n + dn_n == 0, 1'b1);
      if (ex == 2'd1) chk(up_n > dn_n, 1'b1);
      if (ex == 2'd2) chk(dn_n > up_n, 1'b1);
      $display("test done up=%0d down=%0d", up_n, dn_n);
   endtask
   task automatic print_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      n_errors = n_errors + 1;
      print_verdict();
   end
   initial begin
      {resetn, osc_dis, load, run_ref, run_fb, armed} = 6'b000000;
      {ref_per, fb_per, fb_start, duty} = {8'h14, 8'h14, 8'h00, 8'h04};
      {n_errors, cmp_count, up_n, dn_n, seed} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd68984};
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      armed = 1'b1;
      run_case(8'h14, 8'h14, 8'h00, 8'h04, 1'b1, 2'd0);
      run_case(8'h14, 8'h14, 8'h11, 8'h01, 1'b1, 2'd1);
      run_case(8'h14, 8'h14, 8'h03, 8'h0F, 1'b1, 2'd2);
      run_case(8'h0F, 8'h17, 8'h00, 8'h07, 1'b1, 2'd1);
      run_case(8'h17, 8'h0F, 8'h00, 8'h02, 1'b1, 2'd2);
      for (i = 0; i < 8; i = i + 1) begin
         run_case(8'd8 + 8'($unsigned($random(seed)) % 33),
            8'd8 + 8'($unsigned($random(seed)) % 33),
            8'($unsigned($random(seed)) % 8), 8'd1 + 8'($unsigned($random(seed)) % 7),
            1'b1, 2'd3);
      end
      run_case(8'h14, 8'h14, 8'h00, 8'h04, 1'b0, 2'd2);
      print_verdict();
   end
endmodule
